// ===== hdl/iod_map.svh
// Behaviour
// - bit set and clear reach only I/O addresses 0x00 to 0x1F
// - skip tests read one bit directly in I/O addresses 0x00 to 0x1F
// - writing one clears a status flag; writing zero leaves it alone
// - bit set/clear rewrite the whole register, so set flags get cleared
// - dedicated I/O reads and writes use I/O addresses 0x00 to 0x3F
// - load and store reach an I/O register at its address plus 0x20
// - dedicated I/O instructions never reach beyond the 64 locations
// - data addresses 0x60 to 0xFF are reached by load and store only
`ifndef IOD_MAP_SVH
`define IOD_MAP_SVH

// address space limits
`define IOD_BIT_TOP 8'h1F
`define IOD_DATA_OFS 8'h20
`define IOD_EXT_LO 8'h60
`define IOD_IO_HI_ZERO 2'h0
`define IOD_ONE_BIT 8'h01
`define IOD_RST_VAL 8'h00

// register indices in the 64-location I/O space
`define IOD_PORT_A_PIN 6'h00
`define IOD_PORT_A_DIR 6'h01
`define IOD_PORT_A_OUT 6'h02
`define IOD_PORT_B_PIN 6'h03
`define IOD_PORT_B_DIR 6'h04
`define IOD_PORT_B_OUT 6'h05
`define IOD_PORT_C_PIN 6'h06
`define IOD_PORT_C_DIR 6'h07
`define IOD_PORT_C_OUT 6'h08
`define IOD_PORT_D_PIN 6'h09
`define IOD_PORT_D_DIR 6'h0A
`define IOD_PORT_D_OUT 6'h0B
`define IOD_RESV_PROBE 6'h10
`define IOD_TMR0_FLG 6'h15
`define IOD_TMR1_FLG 6'h16
`define IOD_TMR2_FLG 6'h17
`define IOD_PCHG_FLG 6'h1B
`define IOD_XIRQ_FLG 6'h1C
`define IOD_XIRQ_MSK 6'h1D
`define IOD_SCRATCH0 6'h1E
`define IOD_NV_DATA 6'h20
`define IOD_NV_ADDR_LO 6'h21
`define IOD_NV_ADDR_HI 6'h22
`define IOD_TMR_GEN_CTL 6'h23
`define IOD_TMR0_CTL_A 6'h24
`define IOD_TMR0_CTL_B 6'h25
`define IOD_TMR0_CNT 6'h26
`define IOD_TMR0_CMP_A 6'h27
`define IOD_TMR0_CMP_B 6'h28
`define IOD_SCRATCH1 6'h2A
`define IOD_SCRATCH2 6'h2B
`define IOD_SPI_CTL 6'h2C
`define IOD_SPI_STAT 6'h2D
`define IOD_SPI_DATA 6'h2E
`define IOD_CMP_CS 6'h30
`define IOD_DBG_MBOX 6'h31

// implemented bit masks
`define IOD_MSK_FULL 8'hFF
`define IOD_MSK_NONE 8'h00
`define IOD_TMR0_W1C 8'h07
`define IOD_TMR1_W1C 8'h27
`define IOD_TMR2_W1C 8'h07
`define IOD_PCHG_W1C 8'h0F
`define IOD_XIRQ_W1C 8'h07
`define IOD_XIRQ_RW 8'h07
`define IOD_NV_HI_RW 8'h07
`define IOD_GEN_CTL_RW 8'h83
`define IOD_CTL_A_RW 8'hF3
`define IOD_CTL_B_RW 8'hCF
`define IOD_SPI_ST_RO 8'hC0
`define IOD_SPI_ST_RW 8'h01
`define IOD_CMP_RW 8'hCF
`define IOD_CMP_W1C 8'h10
`define IOD_CMP_RO 8'h20
`define IOD_SPI_ST_LSB 6
`define IOD_CMP_OUT_BIT 5
`define IOD_CMP_EVT_BIT 4

`endif

// ===== hdl/iod_pkg.sv
package iod_pkg;

  // operation presented by the core
  typedef enum logic [3:0] {
    IOD_NOP,
    IOD_IN_OP,
    IOD_OUT_OP,
    IOD_SET_IO_BIT_OP,
    IOD_CLEAR_IO_BIT_OP,
    IOD_SKIP_IF_IO_BIT_SET_OP,
    IOD_SKIP_IF_IO_BIT_CLEAR_OP,
    IOD_DATA_LOAD_OP,
    IOD_DATA_STORE_OP
  } iod_op_t;

  typedef struct packed {
    logic valid;
    iod_op_t op;
    logic [7:0] addr;
    logic [2:0] bitsel;
    logic [7:0] wdata;
  } iod_req_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
  } iod_pins_t;

  // one-cycle flag set pulses and status levels from the peripherals
  typedef struct packed {
    logic [7:0] tmr0;
    logic [7:0] tmr1;
    logic [7:0] tmr2;
    logic [7:0] pin_chg;
    logic [7:0] ext_irq;
    logic [1:0] spi_stat;
    logic cmp_out;
    logic cmp_evt;
  } iod_evt_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iod_ext_t;

  typedef struct packed {
    logic [7:0] rw;
    logic [7:0] w1c;
    logic [7:0] ro;
  } iod_mask_t;

  typedef logic [63:0][7:0] iod_image_t;

endpackage

// ===== hdl/iod_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "iod_map.svh"

module iod_top #(
  parameter int IO_LOCS = 64
) (
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // core request
  input wire iod_pkg::iod_req_t i_req,
  // peripheral side
  input wire iod_pkg::iod_pins_t i_pins,
  input wire iod_pkg::iod_evt_t i_evt,
  input wire logic [7:0] i_ext_rdata,
  // core answer
  output logic [7:0] o_rdata,
  output logic o_ack,
  output logic o_skip,
  output logic o_busy,
  output logic o_resv_wr,
  // extended space and register image
  output iod_pkg::iod_ext_t o_ext,
  output iod_pkg::iod_image_t o_image
);

  logic [1:0] rst_sync_r;
  logic rst_n;
  logic busy_r;
  logic ext_load_r;
  iod_pkg::iod_image_t reg_r;
  iod_pkg::iod_image_t hw_set;
  iod_pkg::iod_image_t hw_in;
  logic acc;
  logic is_io;
  logic is_bit;
  logic is_tst;
  logic is_data;
  logic local_hit;
  logic ext_hit;
  logic wr_en;
  logic [5:0] idx;
  logic [7:0] data_off;
  logic [7:0] rd_val;
  logic [7:0] wr_val;
  logic [7:0] bit_sel;
  logic tbit;
  iod_pkg::iod_mask_t cur_mask;

  // reset released through two flops so release is clean
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // implemented bits of each location; unlisted ones stay all zero
  function automatic iod_pkg::iod_mask_t mask_of(input logic [5:0] a);
    iod_pkg::iod_mask_t m;
    m = '0;
    case (a)
      `IOD_PORT_A_PIN, `IOD_PORT_B_PIN, `IOD_PORT_C_PIN,
      `IOD_PORT_D_PIN: begin
        m.ro = `IOD_MSK_FULL;
      end
      `IOD_PORT_A_DIR, `IOD_PORT_A_OUT, `IOD_PORT_B_DIR, `IOD_PORT_B_OUT,
      `IOD_PORT_C_DIR, `IOD_PORT_C_OUT, `IOD_PORT_D_DIR, `IOD_PORT_D_OUT,
      `IOD_SCRATCH0, `IOD_SCRATCH1, `IOD_SCRATCH2, `IOD_NV_DATA,
      `IOD_NV_ADDR_LO, `IOD_TMR0_CNT, `IOD_TMR0_CMP_A, `IOD_TMR0_CMP_B,
      `IOD_SPI_CTL, `IOD_SPI_DATA, `IOD_DBG_MBOX: begin
        m.rw = `IOD_MSK_FULL;
      end
      `IOD_TMR0_FLG: m.w1c = `IOD_TMR0_W1C;
      `IOD_TMR1_FLG: m.w1c = `IOD_TMR1_W1C;
      `IOD_TMR2_FLG: m.w1c = `IOD_TMR2_W1C;
      `IOD_PCHG_FLG: m.w1c = `IOD_PCHG_W1C;
      `IOD_XIRQ_FLG: m.w1c = `IOD_XIRQ_W1C;
      `IOD_XIRQ_MSK: m.rw = `IOD_XIRQ_RW;
      `IOD_NV_ADDR_HI: m.rw = `IOD_NV_HI_RW;
      `IOD_TMR_GEN_CTL: m.rw = `IOD_GEN_CTL_RW;
      `IOD_TMR0_CTL_A: m.rw = `IOD_CTL_A_RW;
      `IOD_TMR0_CTL_B: m.rw = `IOD_CTL_B_RW;
      `IOD_SPI_STAT: begin
        m.rw = `IOD_SPI_ST_RW;
        m.ro = `IOD_SPI_ST_RO;
      end
      `IOD_CMP_CS: begin
        m.rw = `IOD_CMP_RW;
        m.w1c = `IOD_CMP_W1C;
        m.ro = `IOD_CMP_RO;
      end
      default: m = '0;
    endcase
    return m;
  endfunction

  // route peripheral pulses and levels onto their locations
  always_comb begin
    hw_set = '0;
    hw_in = '0;
    hw_in[`IOD_PORT_A_PIN] = i_pins.a;
    hw_in[`IOD_PORT_B_PIN] = i_pins.b;
    hw_in[`IOD_PORT_C_PIN] = i_pins.c;
    hw_in[`IOD_PORT_D_PIN] = i_pins.d;
    hw_in[`IOD_SPI_STAT][`IOD_SPI_ST_LSB +: 2] = i_evt.spi_stat;
    hw_in[`IOD_CMP_CS][`IOD_CMP_OUT_BIT] = i_evt.cmp_out;
    hw_set[`IOD_TMR0_FLG] = i_evt.tmr0;
    hw_set[`IOD_TMR1_FLG] = i_evt.tmr1;
    hw_set[`IOD_TMR2_FLG] = i_evt.tmr2;
    hw_set[`IOD_PCHG_FLG] = i_evt.pin_chg;
    hw_set[`IOD_XIRQ_FLG] = i_evt.ext_irq;
    hw_set[`IOD_CMP_CS][`IOD_CMP_EVT_BIT] = i_evt.cmp_evt;
  end

  // decode the request into a location and an access kind
  always_comb begin
    acc = i_req.valid && !busy_r;
    is_io = (i_req.op == iod_pkg::IOD_IN_OP) ||
            (i_req.op == iod_pkg::IOD_OUT_OP);
    is_bit = (i_req.op == iod_pkg::IOD_SET_IO_BIT_OP) ||
             (i_req.op == iod_pkg::IOD_CLEAR_IO_BIT_OP);
    is_tst = (i_req.op == iod_pkg::IOD_SKIP_IF_IO_BIT_SET_OP) ||
             (i_req.op == iod_pkg::IOD_SKIP_IF_IO_BIT_CLEAR_OP);
    is_data = (i_req.op == iod_pkg::IOD_DATA_LOAD_OP) ||
              (i_req.op == iod_pkg::IOD_DATA_STORE_OP);
    data_off = i_req.addr - `IOD_DATA_OFS;
    idx = is_data ? data_off[5:0] : i_req.addr[5:0];
    local_hit = 1'b0;
    ext_hit = 1'b0;
    if (is_io) begin
      local_hit = (i_req.addr[7:6] == `IOD_IO_HI_ZERO);
    end else if (is_bit || is_tst) begin
      local_hit = (i_req.addr <= `IOD_BIT_TOP);
    end else if (is_data) begin
      local_hit = (i_req.addr >= `IOD_DATA_OFS) &&
                  (i_req.addr < `IOD_EXT_LO);
      ext_hit = (i_req.addr >= `IOD_EXT_LO);
    end
  end

  // read value, bit test and the value a write lays down
  always_comb begin
    rd_val = reg_r[idx];
    cur_mask = mask_of(idx);
    bit_sel = `IOD_ONE_BIT << i_req.bitsel;
    tbit = rd_val[i_req.bitsel];
    wr_val = i_req.wdata;
    wr_en = 1'b0;
    case (i_req.op)
      iod_pkg::IOD_OUT_OP, iod_pkg::IOD_DATA_STORE_OP: begin
        wr_en = acc && local_hit;
      end
      iod_pkg::IOD_SET_IO_BIT_OP: begin
        wr_en = acc && local_hit;
        wr_val = rd_val | bit_sel;
      end
      iod_pkg::IOD_CLEAR_IO_BIT_OP: begin
        wr_en = acc && local_hit;
        wr_val = rd_val & ~bit_sel;
      end
      default: wr_en = 1'b0;
    endcase
  end

  // one storage byte per location; masks make reserved bits constant zero
  generate
    for (genvar g = 0; g < IO_LOCS; g++) begin : g_loc
      localparam iod_pkg::iod_mask_t M = mask_of(6'(g));
      logic hit;
      logic [7:0] wv;
      logic [7:0] reg_nxt;
      assign hit = wr_en && (idx == 6'(g));
      assign wv = hit ? wr_val : `IOD_RST_VAL;
      assign reg_nxt = ((hit ? wr_val : reg_r[g]) & M.rw) |
                       (reg_r[g] & M.w1c & ~wv) |
                       (hw_set[g] & M.w1c) |
                       (hw_in[g] & M.ro);
      always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
          reg_r[g] <= `IOD_RST_VAL;
        end else if (i_ce) begin
          reg_r[g] <= reg_nxt;
        end
      end
    end
  endgenerate

  assign o_image = reg_r;

  // answer to the core; extended accesses take one cycle more
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= `IOD_RST_VAL;
      o_ack <= 1'b0;
      o_skip <= 1'b0;
      o_resv_wr <= 1'b0;
    end else if (i_ce) begin
      o_ack <= 1'b0;
      o_skip <= 1'b0;
      o_resv_wr <= 1'b0;
      if (busy_r) begin
        o_ack <= 1'b1;
        o_rdata <= ext_load_r ? i_ext_rdata : `IOD_RST_VAL;
      end else if (acc && !ext_hit) begin
        o_ack <= 1'b1;
        o_rdata <= local_hit ? rd_val : `IOD_RST_VAL;
        if (is_tst && local_hit) begin
          o_skip <= (i_req.op == iod_pkg::IOD_SKIP_IF_IO_BIT_SET_OP) ?
                    tbit : !tbit;
        end
        o_resv_wr <= wr_en && (cur_mask == '0);
      end
    end
  end

  // extended space strobe; the far side answers during it
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      ext_load_r <= 1'b0;
      o_ext <= '0;
    end else if (i_ce) begin
      if (busy_r) begin
        busy_r <= 1'b0;
        o_ext.req <= 1'b0;
        o_ext.we <= 1'b0;
      end else if (acc && ext_hit) begin
        busy_r <= 1'b1;
        ext_load_r <= (i_req.op == iod_pkg::IOD_DATA_LOAD_OP);
        o_ext.req <= 1'b1;
        o_ext.we <= (i_req.op == iod_pkg::IOD_DATA_STORE_OP);
        o_ext.addr <= i_req.addr;
        o_ext.wdata <= i_req.wdata;
      end
    end
  end

  assign o_busy = busy_r;

  // checks, sampled on every edge; all but a_ext_only_data start only on enabled cycles
  sequence s_local_answer;
    o_ack && !o_ext.req;
  endsequence

  sequence s_ext_answer;
    o_ext.req && !o_ack ##1 o_ack && !o_ext.req;
  endsequence

  property p_bit_range;
    @(posedge i_mclk) disable iff (!rst_n)
      i_ce && acc && is_bit && (i_req.addr > `IOD_BIT_TOP) |-> !wr_en
      ##1 !o_resv_wr;
  endproperty
  a_bit_range: assert property (p_bit_range)
    else $error("bit op above 0x1F changed a register");

  property p_skip;
    @(posedge i_mclk) disable iff (!rst_n)
      i_ce && acc && (i_req.op == iod_pkg::IOD_SKIP_IF_IO_BIT_SET_OP) &&
      (i_req.addr <= `IOD_BIT_TOP) |=> s_local_answer ##0
      (o_skip == $past(reg_r[i_req.addr[4:0]][i_req.bitsel]));
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip-if-set result does not match the bit");

  property p_skip_clr;
    @(posedge i_mclk) disable iff (!rst_n)
      i_ce && acc && (i_req.op == iod_pkg::IOD_SKIP_IF_IO_BIT_CLEAR_OP) &&
      (i_req.addr <= `IOD_BIT_TOP) |=> s_local_answer ##0
      (o_skip == !$past(reg_r[i_req.addr[4:0]][i_req.bitsel]));
  endproperty
  a_skip_clr: assert property (p_skip_clr)
    else $error("skip-if-clear result does not match the bit");

  property p_skip_out;
    @(posedge i_mclk) disable iff (!rst_n)
      i_ce && acc && is_tst && (i_req.addr > `IOD_BIT_TOP) |=> !o_skip;
  endproperty
  a_skip_out: assert property (p_skip_out)
    else $error("skip test answered above 0x1F");

  property p_w1c;
    @(posedge i_mclk) disable iff (!rst_n)
      i_ce && wr_en && (idx == `IOD_TMR0_FLG) &&
      (i_evt.tmr0 == `IOD_MSK_NONE) |=>
      ((reg_r[`IOD_TMR0_FLG] & $past(wr_val)) == `IOD_MSK_NONE) &&
      ((reg_r[`IOD_TMR0_FLG] & ~$past(wr_val)) ==
       ($past(reg_r[`IOD_TMR0_FLG]) & ~$past(wr_val)));
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write-one-to-clear flag misbehaved");

  property p_set_wins;
    @(posedge i_mclk) disable iff (!rst_n)
      i_ce && (i_evt.ext_irq[0]) |=> reg_r[`IOD_XIRQ_FLG][0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("flag set lost against a clear");

  property p_rmw;
    @(posedge i_mclk) disable iff (!rst_n)
      i_ce && acc && (i_req.op == iod_pkg::IOD_SET_IO_BIT_OP) &&
      (i_req.addr[5:0] == `IOD_XIRQ_FLG) &&
      (i_req.addr <= `IOD_BIT_TOP) &&
      (i_evt.ext_irq == `IOD_MSK_NONE) |=>
      (reg_r[`IOD_XIRQ_FLG] == `IOD_MSK_NONE);
  endproperty
  a_rmw: assert property (p_rmw)
    else $error("bit set did not clear every set flag");

  property p_in_map;
    @(posedge i_mclk) disable iff (!rst_n)
      i_ce && acc && (i_req.op == iod_pkg::IOD_IN_OP) &&
      (i_req.addr[7:6] == `IOD_IO_HI_ZERO) |=> s_local_answer ##0
      (o_rdata == $past(reg_r[i_req.addr[5:0]]));
  endproperty
  a_in_map: assert property (p_in_map)
    else $error("I/O read returned the wrong location");

  property p_ld_map;
    @(posedge i_mclk) disable iff (!rst_n)
      i_ce && acc && (i_req.op == iod_pkg::IOD_DATA_LOAD_OP) &&
      (i_req.addr >= `IOD_DATA_OFS) && (i_req.addr < `IOD_EXT_LO) |=>
      o_ack ##0 (o_rdata == $past(reg_r[data_off[5:0]]));
  endproperty
  a_ld_map: assert property (p_ld_map)
    else $error("load did not reach the I/O register at offset 0x20");

  property p_io_bound;
    @(posedge i_mclk) disable iff (!rst_n)
      i_ce && acc && is_io && (i_req.addr[7:6] != `IOD_IO_HI_ZERO) |=>
      o_ack && (o_rdata == `IOD_RST_VAL) && !o_ext.req;
  endproperty
  a_io_bound: assert property (p_io_bound)
    else $error("I/O instruction reached beyond 64 locations");

  property p_ext;
    @(posedge i_mclk) disable iff (!rst_n)
      i_ce && acc && is_data && (i_req.addr >= `IOD_EXT_LO) ##1 i_ce
      |-> s_ext_answer;
  endproperty
  a_ext: assert property (p_ext)
    else $error("extended access not forwarded as one strobe");

  property p_ext_only_data;
    @(posedge i_mclk) disable iff (!rst_n)
      $rose(o_ext.req) |-> $past(is_data) && $past(acc);
  endproperty
  a_ext_only_data: assert property (p_ext_only_data)
    else $error("extended strobe from a non data instruction");

  property p_resv;
    @(posedge i_mclk) disable iff (!rst_n)
      i_ce && acc && (i_req.op == iod_pkg::IOD_OUT_OP) &&
      (i_req.addr == {`IOD_IO_HI_ZERO, `IOD_RESV_PROBE}) |=>
      o_resv_wr ##1 (reg_r[`IOD_RESV_PROBE] == `IOD_RST_VAL);
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved location took a write");

endmodule

`default_nettype wire

// ===== verification/iod_core_mdl.sv
`timescale 1ns/10ps
`default_nettype none
// core model: one request per call, plus the extended-space responder
module iod_core_mdl (
  // answer from the block
  input wire logic i_mclk,
  input wire logic i_ack,
  input wire logic i_skip,
  input wire logic i_resv_wr,
  input wire logic [7:0] i_rdata,
  input wire iod_pkg::iod_ext_t i_ext,
  // requests and extended read data
  output iod_pkg::iod_req_t o_req,
  output logic [7:0] o_ext_rdata
);
  logic [7:0] n_ext = 8'h00;
  logic [7:0] wr_addr = 8'h00;
  logic [7:0] wr_data = 8'h00;

  initial o_req = '0;

  // read data follows the address; inverted outside the strobe so a
  // stale value can never pass for an answer
  assign o_ext_rdata = i_ext.req ? (i_ext.addr ^ 8'hA5) :
                       ~(i_ext.addr ^ 8'hA5);

  // log every extended strobe
  always @(posedge i_mclk) begin
    if (i_ext.req === 1'b1) begin
      n_ext <= n_ext + 8'h01;
      if (i_ext.we) begin
        wr_addr <= i_ext.addr;
        wr_data <= i_ext.wdata;
      end
    end
  end

  // request is presented for one taken edge, then answer awaited
  task automatic xfer(input iod_pkg::iod_op_t op, input logic [7:0] addr,
    input logic [2:0] bsel, input logic [7:0] wd, output logic [7:0] rd,
    output logic sk, output logic rw, output logic ok);
    int n;
    @(posedge i_mclk);
    o_req <= '{valid: 1'b1, op: op, addr: addr, bitsel: bsel, wdata: wd};
    @(posedge i_mclk);
    o_req.valid <= 1'b0;
    ok = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge i_mclk);
      ok = (i_ack === 1'b1);
    end
    rd = i_rdata;
    sk = i_skip;
    rw = i_resv_wr;
  endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic mclk, nrst, ce, ack, skip, resv_wr, busy, skb, rwb, okb;
  logic [7:0] n_busy = 8'h00;
  logic [7:0] rdata, ext_rdata, rd;
  iod_pkg::iod_req_t req;
  iod_pkg::iod_pins_t pins;
  iod_pkg::iod_evt_t evt;
  iod_pkg::iod_ext_t ext;
  iod_pkg::iod_image_t image;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;

  iod_top dut_u (.i_mclk(mclk), .i_nrst(nrst), .i_ce(ce), .i_req(req),
    .i_pins(pins), .i_evt(evt), .i_ext_rdata(ext_rdata), .o_rdata(rdata),
    .o_ack(ack), .o_skip(skip), .o_busy(busy), .o_resv_wr(resv_wr),
    .o_ext(ext), .o_image(image));

  iod_core_mdl core_u (.i_mclk(mclk), .i_ack(ack), .i_skip(skip),
    .i_resv_wr(resv_wr), .i_rdata(rdata), .i_ext(ext), .o_req(req),
    .o_ext_rdata(ext_rdata));

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic io(input iod_pkg::iod_op_t op, input logic [7:0] a,
    input logic [2:0] b, input logic [7:0] d);
    core_u.xfer(op, a, b, d, rd, skb, rwb, okb);
    check("ack", {7'h00, okb}, 8'h01);
  endtask

  // every byte starts cleared
  task automatic t_reset();
    for (int i = 0; i < 64; i++) begin
      check("reset image", image[i], 8'h00);
    end
  endtask

  // dedicated reads and writes, and the 64-location edge
  task automatic t_inout();
    logic [7:0] a [4] = '{8'h02, 8'h1E, 8'h2E, 8'h31};
    for (int i = 0; i < 4; i++) begin
      io(iod_pkg::IOD_OUT_OP, a[i], 3'h0, 8'hA5 ^ a[i]);
      io(iod_pkg::IOD_IN_OP, a[i], 3'h0, 8'h00);
      check("in readback", rd, 8'hA5 ^ a[i]);
      check("image byte", image[a[i][5:0]], 8'hA5 ^ a[i]);
    end
    io(iod_pkg::IOD_OUT_OP, 8'h42, 3'h0, 8'hFF);
    check("image kept", image[2], 8'hA7);
    io(iod_pkg::IOD_IN_OP, 8'h42, 3'h0, 8'h00);
    check("in beyond 64", rd, 8'h00);
  endtask

  // load and store see the same bytes 0x20 higher
  task automatic t_data();
    io(iod_pkg::IOD_DATA_STORE_OP, 8'h25, 3'h0, 8'h5C);
    check("store image", image[5], 8'h5C);
    io(iod_pkg::IOD_DATA_LOAD_OP, 8'h25, 3'h0, 8'h00);
    check("load back", rd, 8'h5C);
    io(iod_pkg::IOD_DATA_LOAD_OP, 8'h05, 3'h0, 8'h00);
    check("load below", rd, 8'h00);
    io(iod_pkg::IOD_DATA_STORE_OP, 8'h4B, 3'h0, 8'h3E);
    io(iod_pkg::IOD_IN_OP, 8'h2B, 3'h0, 8'h00);
    check("store then in", rd, 8'h3E);
  endtask

  // flags clear on one, and bit ops rewrite the whole byte
  task automatic t_flags();
    @(posedge mclk);
    evt <= '{ext_irq: 8'h07, tmr0: 8'hFF, default: '0};
    @(posedge mclk);
    evt <= '0;
    io(iod_pkg::IOD_IN_OP, 8'h1C, 3'h0, 8'h00);
    check("flags set", rd, 8'h07);
    io(iod_pkg::IOD_IN_OP, 8'h15, 3'h0, 8'h00);
    check("unused flag bits", rd, 8'h07);
    io(iod_pkg::IOD_OUT_OP, 8'h15, 3'h0, 8'h05);
    check("timer flags clear", image[21], 8'h02);
    io(iod_pkg::IOD_OUT_OP, 8'h1C, 3'h0, 8'h02);
    check("one clears", image[28], 8'h05);
    io(iod_pkg::IOD_SET_IO_BIT_OP, 8'h1C, 3'h1, 8'h00);
    check("set clears all", image[28], 8'h00);
    io(iod_pkg::IOD_SET_IO_BIT_OP, 8'h04, 3'h3, 8'h00);
    check("set bit", image[4], 8'h08);
    io(iod_pkg::IOD_CLEAR_IO_BIT_OP, 8'h04, 3'h3, 8'h00);
    check("clear bit", image[4], 8'h00);
    io(iod_pkg::IOD_SET_IO_BIT_OP, 8'h2A, 3'h0, 8'h00);
    check("set above 0x1F", image[42], 8'h00);
  endtask

  // skip tests on pin bits
  task automatic t_skip();
    @(posedge mclk);
    pins <= '{b: 8'h10, default: '0};
    repeat (3) @(posedge mclk);
    io(iod_pkg::IOD_SKIP_IF_IO_BIT_SET_OP, 8'h03, 3'h4, 8'h00);
    check("skip set hit", {7'h00, skb}, 8'h01);
    io(iod_pkg::IOD_SKIP_IF_IO_BIT_SET_OP, 8'h03, 3'h3, 8'h00);
    check("skip set miss", {7'h00, skb}, 8'h00);
    io(iod_pkg::IOD_SKIP_IF_IO_BIT_CLEAR_OP, 8'h03, 3'h3, 8'h00);
    check("skip clear hit", {7'h00, skb}, 8'h01);
    io(iod_pkg::IOD_SKIP_IF_IO_BIT_CLEAR_OP, 8'h2A, 3'h0, 8'h00);
    check("skip above 0x1F", {7'h00, skb}, 8'h00);
  endtask

  // extended space by load and store only, one busy cycle each
  task automatic t_ext();
    logic [7:0] n0;
    logic [7:0] b0;
    b0 = n_busy;
    io(iod_pkg::IOD_DATA_STORE_OP, 8'h80, 3'h0, 8'h3C);
    check("ext addr", core_u.wr_addr, 8'h80);
    check("ext data", core_u.wr_data, 8'h3C);
    io(iod_pkg::IOD_DATA_LOAD_OP, 8'hFF, 3'h0, 8'h00);
    check("ext load top", rd, 8'h5A);
    io(iod_pkg::IOD_DATA_LOAD_OP, 8'h60, 3'h0, 8'h00);
    check("ext load low", rd, 8'hC5);
    n0 = core_u.n_ext;
    io(iod_pkg::IOD_IN_OP, 8'h60, 3'h0, 8'h00);
    check("in to ext", rd, 8'h00);
    check("no ext strobe", core_u.n_ext, n0);
    check("busy cycles", n_busy - b0, 8'h03);
  endtask

  // reserved place: deliberate write to it; a no-op touches nothing
  task automatic t_resv();
    io(iod_pkg::IOD_IN_OP, 8'h10, 3'h0, 8'h00);
    check("resv read", rd, 8'h00);
    io(iod_pkg::IOD_OUT_OP, 8'h10, 3'h0, 8'hFF);
    check("resv flag", {7'h00, rwb}, 8'h01);
    check("resv image", image[16], 8'h00);
    io(iod_pkg::IOD_OUT_OP, 8'h1D, 3'h0, 8'h07);
    check("legal no flag", {7'h00, rwb}, 8'h00);
    io(iod_pkg::IOD_NOP, 8'h1D, 3'h0, 8'hFF);
    check("nop reads zero", rd, 8'h00);
    check("nop no write", image[29], 8'h07);
  endtask

  // a low enable freezes the block: nothing is taken or acked
  task automatic t_ce();
    @(posedge mclk);
    ce <= 1'b0;
    core_u.xfer(iod_pkg::IOD_OUT_OP, 8'h1E, 3'h0, 8'h77, rd, skb, rwb, okb);
    ce <= 1'b1;
    check("frozen ack", {7'h00, okb}, 8'h00);
    check("frozen image", image[30], 8'hBB);
    io(iod_pkg::IOD_IN_OP, 8'h1E, 3'h0, 8'h00);
    check("after thaw", rd, 8'hBB);
  endtask

  // extended accesses hold the block busy for exactly one cycle each
  always @(posedge mclk) begin
    if (busy === 1'b1) begin
      n_busy <= n_busy + 8'h01;
    end
  end

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // hang guard, far above the expected run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    pins = '0;
    evt = '0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_inout();
    t_data();
    t_flags();
    t_skip();
    t_ext();
    t_resv();
    t_ce();
    close_out();
  end
endmodule
`default_nettype wire
